//--- vec_round_defs.svh
`ifndef VEC_ROUND_DEFS_SVH
`define VEC_ROUND_DEFS_SVH

// Single precision element layout
`define ELEM_W 32
`define ELEM_SIGN_BIT 31
`define ELEM_EXP_HI 30
`define ELEM_EXP_LO 23
`define ELEM_FRAC_HI 22
`define EXP_ZERO 8'h00
`define EXP_HALF 8'h7e
`define EXP_ONE 8'h7f
`define EXP_INT_TOP 8'h96
`define EXP_KEEP_MIN 8'h97
`define ONE_MAG 31'h3f800000
`define ZERO_MAG 31'h00000000

// Exception vectors
`define VEC_UNAVAIL_OFS 32'h00000f20
`define DSI_OFS 32'h00000f40
`define ASSIST_OFS 32'h00000f60
`define BASE_LOW 32'h00000000
`define BASE_HIGH 32'hfff00000

// Stream table queue
`define STQ_DEPTH 4
`define ADDR_W 32
`define SAVE_MASK_RESET 32'h00000000

`endif

//--- vec_round_pkg.sv
package vec_round_pkg;

    typedef enum logic [1:0] {
        RND_NEAREST,
        RND_TRUNC,
        RND_CEIL,
        RND_FLOOR
    } round_op_t;

    typedef enum logic [3:0] {
        VOP_ROUND,
        VOP_FLOAT,
        VOP_LOAD,
        VOP_STORE,
        VOP_TOUCH,
        VOP_STOP,
        VOP_SAVE_RD,
        VOP_SAVE_WR,
        VOP_OTHER
    } vop_t;

    typedef enum logic [1:0] {
        EXC_NONE,
        EXC_UNAVAIL,
        EXC_DSI,
        EXC_ASSIST
    } exc_t;

    typedef enum logic [1:0] {
        SRCH_IDLE,
        SRCH_WAIT
    } srch_state_t;

endpackage : vec_round_pkg

//--- round_elem.sv
`timescale 1ns/1ps
`include "vec_round_defs.svh"

module round_elem (
    // Operand
    input wire logic [31:0] elem_in,
    input wire vec_round_pkg::round_op_t op_in,
    // Result
    output logic [31:0] result_out,
    output logic denorm_out
);

    wire sign = elem_in[`ELEM_SIGN_BIT];
    wire [7:0] bexp = elem_in[`ELEM_EXP_HI:`ELEM_EXP_LO];
    wire [22:0] frac = elem_in[`ELEM_FRAC_HI:0];
    wire is_zero = (bexp == `EXP_ZERO) && (frac == 23'h000000);
    wire is_den = (bexp == `EXP_ZERO) && (frac != 23'h000000);
    wire keep = (bexp >= `EXP_KEEP_MIN);
    wire below_one = (bexp < `EXP_ONE);
    wire [7:0] fb_diff = `EXP_INT_TOP - bexp;
    wire [4:0] frac_bits = fb_diff[4:0];
    wire [24:0] sig = {2'b01, frac};
    wire [24:0] lsb_unit = 25'h0000001 << frac_bits;
    wire [24:0] half_unit = lsb_unit >> 1;
    wire [24:0] mask = lsb_unit - 25'h0000001;
    wire [24:0] int_part = sig & ~mask;
    wire [24:0] rem = sig & mask;
    wire frac_nz = |rem;
    wire has_frac = (frac_bits != 5'h00);
    wire above_half = has_frac && (rem > half_unit);
    wire at_half = has_frac && (rem == half_unit);
    wire odd = |(sig & lsb_unit);
    wire inc_near = above_half || (at_half && odd);
    wire inc_ceil = !sign && frac_nz;
    wire inc_floor = sign && frac_nz;
    logic inc;
    wire [24:0] sum = int_part + (inc ? lsb_unit : 25'h0000000);
    wire carry = sum[24];
    wire [7:0] res_exp = carry ? bexp + 8'h01 : bexp;
    wire [22:0] res_frac = carry ? 23'h000000 : sum[22:0];
    wire small_near = (bexp == `EXP_HALF) && (frac != 23'h000000);
    logic small_one;

    always_comb begin
        case (op_in)
            vec_round_pkg::RND_NEAREST: begin
                inc = inc_near;
                small_one = small_near;
            end
            vec_round_pkg::RND_CEIL: begin
                inc = inc_ceil;
                small_one = !sign;
            end
            vec_round_pkg::RND_FLOOR: begin
                inc = inc_floor;
                small_one = sign;
            end
            default: begin
                inc = 1'b0;
                small_one = 1'b0;
            end
        endcase
    end

    assign denorm_out = is_den;

    always_comb begin
        if (is_zero) begin
            result_out = elem_in;
        end else if (is_den) begin
            result_out = {sign, `ZERO_MAG};
        end else if (keep) begin
            result_out = elem_in;
        end else if (below_one) begin
            result_out = {sign, small_one ? `ONE_MAG : `ZERO_MAG};
        end else begin
            result_out = {sign, res_exp, res_frac};
        end
    end

endmodule : round_elem

//--- vec_round_faults.sv
// Behaviour
// - Elements with unbiased exponent 24 or more return unchanged in both modes.
// - Exponents 0..23 round nearest, truncate, toward plus or minus infinity.
// - Negative exponent -1: nearest rounds, truncate/ceiling give -0, floor -1.0.
// - Positive tiny normal: ceiling +1.0, others +0; a denormal gives a zero of its own sign from all; exponent -1 nearest rounds.
// - A zero input gives a zero of the same sign from all operations.
// - Strict mode: denormal input traps instead of giving a result.
// - Rounding never outputs a denormal number.
// - Underflow and denormal detection use the value before rounding.
// - Only vector-unavailable, data-storage and assist exceptions are raised.
// - Non-stream, non-save op with unit disabled raises unavailable at offset 0x00F20.
// - Stream touch and stop never raise unavailable.
// - Save mask register access never faults on a disabled unit.
// - Load/store data-storage faults only on protection violation, missing page entry or direct-store segment.
// - Load/store to a direct-store segment raises the data-storage fault.
// - Strict mode: denormal input or output raises the assist exception.
// - Stream touch searches start after retirement; MMU faults abort them.
// - An aborted queue search skips its line fetch instead of retrying.
`timescale 1ns/1ps
`include "vec_round_defs.svh"

module vec_round_faults #(
    parameter int LANES = 4,
    parameter int STQ_DEPTH = `STQ_DEPTH
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Machine state
    input wire logic unit_enable_bit_in,
    input wire logic prefix_select_bit_in,
    input wire logic strict_mode_in,
    // Issue
    input wire logic issue_valid_in,
    input wire vec_round_pkg::vop_t issue_op_in,
    input wire vec_round_pkg::round_op_t round_op_in,
    input wire logic [LANES*32-1:0] operand_in,
    input wire logic fp_denorm_in,
    input wire logic [31:0] save_data_in,
    // Memory translation status
    input wire logic [`ADDR_W-1:0] mem_addr_in,
    input wire logic prot_violation_in,
    input wire logic pte_miss_in,
    input wire logic direct_store_in,
    // Table search port
    input wire logic search_done_in,
    input wire logic search_abort_in,
    input wire logic tlbsync_in,
    // Result
    output logic result_valid_out,
    output logic [LANES*32-1:0] result_out,
    output logic [31:0] save_mask_out,
    output logic mem_go_out,
    // Exception
    output logic exc_valid_out,
    output vec_round_pkg::exc_t exc_kind_out,
    output logic [31:0] exc_vector_out,
    // Stream queue
    output logic search_req_out,
    output logic [`ADDR_W-1:0] search_addr_out,
    output logic fetch_req_out,
    output logic [`ADDR_W-1:0] fetch_addr_out,
    output logic fetch_skip_out,
    output logic [$clog2(STQ_DEPTH+1)-1:0] stq_count_out
);

    localparam int PTR_W = (STQ_DEPTH > 1) ? $clog2(STQ_DEPTH) : 1;
    localparam int CNT_W = $clog2(STQ_DEPTH+1);

    initial begin
        if (LANES < 1) begin
            $error("LANES must be at least one");
        end
        if (STQ_DEPTH < 2 || (STQ_DEPTH & (STQ_DEPTH - 1)) != 0) begin
            $error("STQ_DEPTH must be a power of two of at least two");
        end
    end

    // Issue decode
    wire is_round = issue_valid_in && (issue_op_in == vec_round_pkg::VOP_ROUND);
    wire is_float = issue_valid_in && (issue_op_in == vec_round_pkg::VOP_FLOAT);
    wire is_load = issue_valid_in && (issue_op_in == vec_round_pkg::VOP_LOAD);
    wire is_store = issue_valid_in && (issue_op_in == vec_round_pkg::VOP_STORE);
    wire is_touch = issue_valid_in && (issue_op_in == vec_round_pkg::VOP_TOUCH);
    wire is_stop = issue_valid_in && (issue_op_in == vec_round_pkg::VOP_STOP);
    wire is_save_rd = issue_valid_in && (issue_op_in == vec_round_pkg::VOP_SAVE_RD);
    wire is_save_wr = issue_valid_in && (issue_op_in == vec_round_pkg::VOP_SAVE_WR);
    wire is_mem = is_load || is_store;
    wire is_stream = is_touch || is_stop;
    wire is_save = is_save_rd || is_save_wr;

    // Per-lane rounding
    logic [LANES*32-1:0] round_res;
    logic [LANES-1:0] lane_den;

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            round_elem u_round_elem (
                .elem_in(operand_in[g*32 +: 32]),
                .op_in(round_op_in),
                .result_out(round_res[g*32 +: 32]),
                .denorm_out(lane_den[g])
            );
        end
    endgenerate

    wire any_den_in = |lane_den;
    wire float_den = is_float && (any_den_in || fp_denorm_in);

    wire strict = strict_mode_in;

    wire unavail = issue_valid_in && !unit_enable_bit_in && !is_stream && !is_save;

    wire dsi = is_mem && (prot_violation_in || pte_miss_in || direct_store_in);

    wire assist = strict && ((is_round && any_den_in) || float_den);

    vec_round_pkg::exc_t exc_sel;
    assign exc_sel = unavail ? vec_round_pkg::EXC_UNAVAIL :
                     dsi ? vec_round_pkg::EXC_DSI :
                     assist ? vec_round_pkg::EXC_ASSIST :
                     vec_round_pkg::EXC_NONE;
    wire exc_any = (exc_sel != vec_round_pkg::EXC_NONE);

    wire [31:0] vec_base = prefix_select_bit_in ? `BASE_HIGH : `BASE_LOW;
    wire [31:0] vec_ofs = (exc_sel == vec_round_pkg::EXC_UNAVAIL) ? `VEC_UNAVAIL_OFS :
                          (exc_sel == vec_round_pkg::EXC_DSI) ? `DSI_OFS :
                          `ASSIST_OFS;
    wire [31:0] vec_addr = vec_base | vec_ofs;

    wire round_ok = is_round && !exc_any;
    wire save_rd_ok = is_save_rd;
    wire [LANES*32-1:0] result_nxt = round_ok ? round_res :
                                     save_rd_ok ? {{(LANES-1)*32{1'b0}}, save_mask_out} :
                                     '0;
    wire result_valid_nxt = round_ok || save_rd_ok;

    // Result and exception registers
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            result_valid_out <= 1'b0;
            result_out <= '0;
            exc_valid_out <= 1'b0;
            exc_kind_out <= vec_round_pkg::EXC_NONE;
            exc_vector_out <= 32'h00000000;
            mem_go_out <= 1'b0;
        end else begin
            result_valid_out <= result_valid_nxt;
            result_out <= result_nxt;
            exc_valid_out <= exc_any;
            exc_kind_out <= exc_sel;
            exc_vector_out <= exc_any ? vec_addr : 32'h00000000;
            mem_go_out <= is_mem && !exc_any;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            save_mask_out <= `SAVE_MASK_RESET;
        end else if (is_save_wr) begin
            save_mask_out <= save_data_in;
        end
    end

    // Stream table queue storage
    logic [`ADDR_W-1:0] stq_mem [STQ_DEPTH];
    logic [PTR_W-1:0] head_r;
    logic [PTR_W-1:0] tail_r;
    logic [CNT_W-1:0] count_r;
    vec_round_pkg::srch_state_t state_r;
    vec_round_pkg::srch_state_t state_nxt;

    wire stq_full = (count_r == CNT_W'(STQ_DEPTH));
    wire stq_empty = (count_r == '0);
    wire push = is_touch && !unavail && !stq_full && !is_stop;
    wire pop = (state_r == vec_round_pkg::SRCH_IDLE) && !stq_empty && !is_stop;
    wire in_wait = (state_r == vec_round_pkg::SRCH_WAIT);
    wire cancel = in_wait && (is_stop || tlbsync_in);
    wire done_ok = in_wait && !cancel && search_done_in && !search_abort_in;
    wire done_skip = in_wait && ((search_done_in && search_abort_in) || cancel);

    wire [CNT_W-1:0] count_nxt = is_stop ? '0 :
                                 (push && !pop) ? count_r + CNT_W'(1) :
                                 (pop && !push) ? count_r - CNT_W'(1) :
                                 count_r;

    always_comb begin
        case (state_r)
            vec_round_pkg::SRCH_IDLE: begin
                state_nxt = pop ? vec_round_pkg::SRCH_WAIT : vec_round_pkg::SRCH_IDLE;
            end
            vec_round_pkg::SRCH_WAIT: begin
                state_nxt = (cancel || search_done_in) ? vec_round_pkg::SRCH_IDLE
                                                       : vec_round_pkg::SRCH_WAIT;
            end
            default: begin
                state_nxt = vec_round_pkg::SRCH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (push) begin
            stq_mem[tail_r] <= mem_addr_in;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            head_r <= '0;
            tail_r <= '0;
            count_r <= '0;
            state_r <= vec_round_pkg::SRCH_IDLE;
        end else begin
            head_r <= is_stop ? '0 : (pop ? head_r + PTR_W'(1) : head_r);
            tail_r <= is_stop ? '0 : (push ? tail_r + PTR_W'(1) : tail_r);
            count_r <= count_nxt;
            state_r <= state_nxt;
        end
    end

    // Search request and fetch outcome
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            search_addr_out <= '0;
            fetch_req_out <= 1'b0;
            fetch_addr_out <= '0;
            fetch_skip_out <= 1'b0;
        end else begin
            if (pop) begin
                search_addr_out <= stq_mem[head_r];
            end
            fetch_req_out <= done_ok;
            fetch_addr_out <= done_ok ? search_addr_out : fetch_addr_out;
            fetch_skip_out <= done_skip;
        end
    end

    assign search_req_out = in_wait;
    assign stq_count_out = count_r;

endmodule : vec_round_faults

//--- vec_round_faults_asserts.sv
`timescale 1ns/1ps
`include "vec_round_defs.svh"
module vec_round_faults_asserts #(
    parameter int LANES = 4
) (
    // Clock, state, issue
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic unit_enable_bit_in,
    input wire logic prefix_select_bit_in,
    input wire logic strict_mode_in,
    input wire logic issue_valid_in,
    input wire vec_round_pkg::vop_t issue_op_in,
    input wire logic [LANES*32-1:0] operand_in,
    input wire logic direct_store_in,
    input wire logic search_done_in,
    input wire logic search_abort_in,
    input wire logic tlbsync_in,
    // Outputs
    input wire logic result_valid_out,
    input wire logic [LANES*32-1:0] result_out,
    input wire logic mem_go_out,
    input wire logic exc_valid_out,
    input wire vec_round_pkg::exc_t exc_kind_out,
    input wire logic [31:0] exc_vector_out,
    input wire logic search_req_out,
    input wire logic fetch_req_out,
    input wire logic fetch_skip_out
);
    logic strm;
    logic sav;
    logic mem;
    logic rnd;
    assign strm = issue_op_in inside {vec_round_pkg::VOP_TOUCH, vec_round_pkg::VOP_STOP};
    assign sav = issue_op_in inside {vec_round_pkg::VOP_SAVE_RD, vec_round_pkg::VOP_SAVE_WR};
    assign mem = issue_op_in inside {vec_round_pkg::VOP_LOAD, vec_round_pkg::VOP_STORE};
    assign rnd = issue_op_in == vec_round_pkg::VOP_ROUND;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    unavail_vec_a:
        assert property (issue_valid_in && !unit_enable_bit_in && !strm && !sav |=>
        exc_valid_out && exc_kind_out == vec_round_pkg::EXC_UNAVAIL && exc_vector_out ==
        (($past(prefix_select_bit_in) ? `BASE_HIGH : `BASE_LOW) | `VEC_UNAVAIL_OFS))
        else $error("unavailable fault wrong");
    stream_quiet_a:
        assert property (issue_valid_in && strm |=> !exc_valid_out) else $error("stream faulted");
    save_quiet_a:
        assert property (issue_valid_in && sav |=> !exc_valid_out) else $error("save faulted");
    exc_kinds_a:
        assert property (exc_valid_out |-> exc_kind_out != vec_round_pkg::EXC_NONE)
        else $error("bad exception kind");
    direct_dsi_a:
        assert property (issue_valid_in && unit_enable_bit_in && mem && direct_store_in |=>
        exc_kind_out == vec_round_pkg::EXC_DSI && !mem_go_out) else $error("direct store missed");
    big_keep_a:
        assert property (issue_valid_in && rnd && operand_in[30:23] >= `EXP_KEEP_MIN |=>
        !result_valid_out || result_out[31:0] == $past(operand_in[31:0]))
        else $error("large element changed");
    zero_sign_a:
        assert property (issue_valid_in && rnd && operand_in[30:23] == 8'h00 |=>
        !result_valid_out || result_out[31:0] == {$past(operand_in[31]), 31'h0})
        else $error("zero sign lost");
    no_denorm_a:
        assert property (result_valid_out |-> result_out[30:23] != 8'h00 ||
        result_out[22:0] == 23'h0) else $error("denormal result");
    strict_trap_a:
        assert property (issue_valid_in && unit_enable_bit_in && rnd && strict_mode_in &&
        operand_in[30:23] == 8'h00 && operand_in[22:0] != 23'h0 |=> exc_valid_out &&
        exc_kind_out == vec_round_pkg::EXC_ASSIST && !result_valid_out)
        else $error("strict denormal not trapped");
    abort_skip_a:
        assert property (search_req_out && (tlbsync_in || search_done_in && search_abort_in)
        |=> fetch_skip_out && !fetch_req_out) else $error("aborted search fetched");
    cover property (issue_valid_in && strm);
    cover property (exc_valid_out && exc_kind_out == vec_round_pkg::EXC_ASSIST);
    cover property (fetch_skip_out);
endmodule : vec_round_faults_asserts
bind vec_round_faults vec_round_faults_asserts #(.LANES(LANES)) u_chk (.*);

//--- vector_float_round_and_faults_bench.sv
`timescale 1ns/1ps
module vector_float_round_and_faults_bench;
    logic clock_in = 0, nrst_in = 0, en = 1, pfx = 0, strict = 0, iv = 0;
    logic pv = 0, pm = 0, ds = 0, sd = 0, sa = 0, fpd = 0, rv, mg, ev, sr, fr, fs;
    vec_round_pkg::vop_t op = vec_round_pkg::VOP_OTHER;
    vec_round_pkg::round_op_t rop = vec_round_pkg::RND_NEAREST;
    vec_round_pkg::exc_t ek;
    logic [127:0] opnd = 0, res;
    logic [31:0] sdat = 0, addr = 0, evec, smask, saddr, faddr;
    logic [2:0] cnt;
    int fails = 0, total_checks = 0, cyc = 0;
    vec_round_faults i_dut (.clock_in(clock_in), .nrst_in(nrst_in),
        .unit_enable_bit_in(en), .prefix_select_bit_in(pfx), .strict_mode_in(strict),
        .issue_valid_in(iv), .issue_op_in(op), .round_op_in(rop), .operand_in(opnd),
        .fp_denorm_in(fpd), .save_data_in(sdat), .mem_addr_in(addr),
        .prot_violation_in(pv), .pte_miss_in(pm), .direct_store_in(ds),
        .search_done_in(sd), .search_abort_in(sa), .tlbsync_in(1'b0),
        .result_valid_out(rv), .result_out(res), .save_mask_out(smask), .mem_go_out(mg),
        .exc_valid_out(ev), .exc_kind_out(ek), .exc_vector_out(evec),
        .search_req_out(sr), .search_addr_out(saddr), .fetch_req_out(fr),
        .fetch_addr_out(faddr), .fetch_skip_out(fs), .stq_count_out(cnt));
    initial forever #10 clock_in = ~clock_in;
    task chk_w(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask : chk_w
    task chk_k(input vec_round_pkg::exc_t g, input vec_round_pkg::exc_t e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t exception kind %0d", $time, g);
        end
    endtask : chk_k
    task iss(input vec_round_pkg::vop_t o, input logic [127:0] d);
        @(posedge clock_in);
        iv <= 1'b1;
        op <= o;
        opnd <= d;
        @(posedge clock_in);
        iv <= 1'b0;
        #1;
    endtask : iss
    task t_round(input logic [127:0] d, input logic [127:0] e0, e1, e2, e3);
        logic [127:0] e [4];
        e = '{e0, e1, e2, e3};
        for (int i = 0; i < 4; i++) begin
            rop <= vec_round_pkg::round_op_t'(i[1:0]);
            iss(vec_round_pkg::VOP_ROUND, d);
            chk_w({31'h0, rv}, 32'h1);
            for (int g = 0; g < 4; g++) begin
                chk_w(res[g*32+:32], e[i][g*32+:32]);
            end
        end
        $display("round table done");
    endtask : t_round
    task t_strict;
        strict <= 1'b1;
        rop <= vec_round_pkg::RND_NEAREST;
        iss(vec_round_pkg::VOP_ROUND, {96'h0, 32'h00000001});
        chk_k(ek, vec_round_pkg::EXC_ASSIST);
        chk_w(evec, 32'h00000f60);
        chk_w({31'h0, rv}, 32'h0);
        fpd <= 1'b1;
        iss(vec_round_pkg::VOP_FLOAT, 128'h0);
        chk_k(ek, vec_round_pkg::EXC_ASSIST);
        fpd <= 1'b0;
        iss(vec_round_pkg::VOP_ROUND, {96'h0, 32'h40200000});
        chk_w(res[31:0], 32'h40000000);
        strict <= 1'b0;
        $display("strict done");
    endtask : t_strict
    task t_unavail;
        en <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            pfx <= p[0];
            iss(vec_round_pkg::VOP_LOAD, 128'h0);
            chk_k(ek, vec_round_pkg::EXC_UNAVAIL);
            chk_w(evec, p[0] ? 32'hfff00f20 : 32'h00000f20);
            chk_w({31'h0, mg}, 32'h0);
        end
        pfx <= 1'b0;
        sdat <= 32'h5a5a0001;
        iss(vec_round_pkg::VOP_SAVE_WR, 128'h0);
        chk_w(smask, 32'h5a5a0001);
        iss(vec_round_pkg::VOP_SAVE_RD, 128'h0);
        chk_w(res[31:0], 32'h5a5a0001);
        chk_w({31'h0, ev}, 32'h0);
        iss(vec_round_pkg::VOP_STOP, 128'h0);
        chk_w({31'h0, ev}, 32'h0);
        $display("unavailable done");
    endtask : t_unavail
    task t_dsi;
        en <= 1'b1;
        pv <= 1'b1;
        iss(vec_round_pkg::VOP_LOAD, 128'h0);
        chk_k(ek, vec_round_pkg::EXC_DSI);
        chk_w(evec, 32'h00000f40);
        pv <= 1'b0;
        pm <= 1'b1;
        iss(vec_round_pkg::VOP_STORE, 128'h0);
        chk_k(ek, vec_round_pkg::EXC_DSI);
        pm <= 1'b0;
        ds <= 1'b1;
        iss(vec_round_pkg::VOP_STORE, 128'h0);
        chk_k(ek, vec_round_pkg::EXC_DSI);
        ds <= 1'b0;
        iss(vec_round_pkg::VOP_LOAD, 128'h0);
        chk_w({30'h0, mg, ev}, 32'h2);
        $display("storage fault done");
    endtask : t_dsi
    task t_stream(input logic [31:0] a, input logic ab);
        int k;
        en <= 1'b0;
        addr <= a;
        iss(vec_round_pkg::VOP_TOUCH, 128'h0);
        chk_w({31'h0, ev}, 32'h0);
        k = 0;
        while (sr !== 1'b1 && k < 8) begin
            @(posedge clock_in);
            #1;
            k++;
        end
        chk_w(saddr, a);
        @(posedge clock_in);
        sd <= 1'b1;
        sa <= ab;
        @(posedge clock_in);
        sd <= 1'b0;
        sa <= 1'b0;
        #1;
        chk_w({30'h0, fr, fs}, ab ? 32'h1 : 32'h2);
        if (!ab) chk_w(faddr, a);
        en <= 1'b1;
        $display("stream done");
    endtask : t_stream
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (20) @(posedge clock_in);
        nrst_in <= 1'b1;
        t_round({32'h4b800001, 32'h3e800000, 32'hbf400000, 32'h40200000},
            {32'h4b800001, 32'h00000000, 32'hbf800000, 32'h40000000},
            {32'h4b800001, 32'h00000000, 32'h80000000, 32'h40000000},
            {32'h4b800001, 32'h3f800000, 32'h80000000, 32'h40400000},
            {32'h4b800001, 32'h00000000, 32'hbf800000, 32'h40000000});
        t_round({32'h80000005, 32'h00000001, 32'h00000000, 32'h80000000},
            {32'h80000000, 32'h00000000, 32'h00000000, 32'h80000000},
            {32'h80000000, 32'h00000000, 32'h00000000, 32'h80000000},
            {32'h80000000, 32'h00000000, 32'h00000000, 32'h80000000},
            {32'h80000000, 32'h00000000, 32'h00000000, 32'h80000000});
        t_strict;
        t_unavail;
        t_dsi;
        t_stream(32'h00001000, 1'b0);
        t_stream(32'h00002000, 1'b1);
        tally_and_finish;
    end
endmodule : vector_float_round_and_faults_bench
